// [dv/ncosc_assertions.sv]
// Port checks for the oscillator block
`timescale 1ns/1ns

module ncosc_assertions
  import ncosc_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        resetn,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Oscillator side
  input wire ncosc_pkg::ncosc_clk_src_t clk_src,
  input wire logic        sleep_req,
  input wire logic        osc_out,
  input wire logic        fast_osc_keep,
  input wire logic        irq
);
  // ------------------------------------
  // Shadow of control and clock select
  // ------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] clk_r;
  logic       wr_ev;
  logic       clr_ev;
  logic       keep_c;
  logic       ints_on;

  assign wr_ev   = psel && penable && pready && pwrite;
  assign clr_ev  = psel && penable && pready && (pwrite || paddr == ADDR_STATUS);
  assign keep_c  = ctrl_r[CTRL_EN_BIT] && clk_r[1:0] == CKS_FAST && sleep_req;
  assign ints_on = &{ctrl_r[CTRL_EN_BIT], ctrl_r[CTRL_GIE_BIT:CTRL_OVIE_BIT]};

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= RST_BYTE;
      clk_r  <= RST_BYTE;
    end else if (wr_ev) begin
      if (paddr == ADDR_CTRL) ctrl_r <= pwdata[7:0];
      if (paddr == ADDR_CLK) clk_r <= pwdata[7:0];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  pready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no bus answer");
  err_map_a: assert property (pready |-> pslverr == (paddr > ADDR_MASK || paddr[1:0] != 2'h0))
    else $error("wrong pslverr");
  upper_zero_a: assert property (pready && !pwrite && paddr == ADDR_INC_UPR |->
    prdata[31:4] == 28'h0) else $error("upper bits not zero");
  clk_read_a: assert property (pready && !pwrite && paddr == ADDR_CLK |->
    prdata == {24'h0, clk_r & 8'he3}) else $error("clock select readback");
  irq_gate_a: assert property (irq |-> ints_on || $past(ints_on))
    else $error("irq without enables");
  irq_hold_a: assert property ($fell(irq) |-> $past(clr_ev) || $past(clr_ev, 2)
    || $past(clr_ev, 3)) else $error("irq dropped by itself");
  keep_osc_a: assert property (fast_osc_keep == $past(keep_c))
    else $error("fast oscillator request");
  idle_out_a: assert property ((!ctrl_r[CTRL_EN_BIT] && !wr_ev)[*3] |=> $stable(osc_out))
    else $error("output moved while disabled");

  cover property (irq ##1 !irq);
  cover property (pready && pslverr);
  cover property ($rose(fast_osc_keep));
endmodule

bind ncosc_top ncosc_assertions chk (
  .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .clk_src(clk_src), .sleep_req(sleep_req), .osc_out(osc_out),
  .fast_osc_keep(fast_osc_keep), .irq(irq)
);

// [dv/testbench.sv]
// Self-checking bench for the oscillator block
`timescale 1ns/1ns

module testbench;
  import ncosc_pkg::*;

  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] v;
    logic        err;
  } ncosc_row_t;

  logic           ref_clk = 1'b0;
  logic           resetn = 1'b0;
  logic           psel = 1'b0;
  logic           penable = 1'b0;
  logic           pwrite = 1'b0;
  logic [7:0]     paddr = 8'h00;
  logic [31:0]    pwdata = 32'h0;
  logic           pready, pslverr, osc_out, fast_osc_keep, irq;
  logic [31:0]    prdata;
  ncosc_clk_src_t clk_src = '0;
  logic           sleep_req = 1'b0;
  int             fails = 0;
  int             n_tests = 0;
  int             hi = 0;

  ncosc_row_t rows [9] = '{
    '{1'b0, ADDR_CTRL, 32'h0, 1'b0},
    '{1'b0, ADDR_INC_HIGH, 32'h0, 1'b0},
    '{1'b1, ADDR_CLK, 32'hff, 1'b0},
    '{1'b0, ADDR_CLK, 32'he3, 1'b0},
    '{1'b1, ADDR_ACC_LOW, 32'ha5, 1'b0},
    '{1'b0, ADDR_ACC_LOW, 32'ha5, 1'b0},
    '{1'b1, ADDR_INC_UPR, 32'hff, 1'b0},
    '{1'b0, ADDR_INC_UPR, 32'h0f, 1'b0},
    '{1'b0, 8'h28, 32'h0, 1'b1}
  };

  always #5 ref_clk = ~ref_clk;

  ncosc_top dut (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .clk_src(clk_src), .sleep_req(sleep_req), .osc_out(osc_out),
    .fast_osc_keep(fast_osc_keep), .irq(irq)
  );

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask

  // Reads compare data against v; a write only checks the ready and error flags
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
                     input logic err = 1'b0);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? v : 32'h0;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk("pready", 32'h1, {31'h0, pready});
    chk("pslverr", {31'h0, err}, {31'h0, pslverr});
    if (!w) chk("prdata", v, prdata);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Input clock is 8 ref cycles; output level tallied once per input period
  task automatic edges(input int n, input int b);
    repeat (n) begin
      clk_src[b] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      clk_src[b] <= 1'b0;
      repeat (4) @(posedge ref_clk);
      if (osc_out === 1'b1) hi++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    foreach (rows[i]) apb(rows[i].w, rows[i].a, rows[i].v, rows[i].err);
    // Increment of half the range overflows on every second input edge
    apb(1'b1, ADDR_INC_UPR, 32'h08);
    apb(1'b1, ADDR_INC_HIGH, 32'h00);
    apb(1'b1, ADDR_MASK, 32'h01);
    apb(1'b1, ADDR_CLK, 32'h01);
    apb(1'b1, ADDR_CTRL, 32'h8e);
    edges(2, 1);
    repeat (20) @(posedge ref_clk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b0, ADDR_STATUS, 32'h1);
    repeat (4) @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, ADDR_CTRL, 32'h86);
    edges(2, 1);
    repeat (20) @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b0, ADDR_STATUS, 32'h1);
    // Overflow every 8 input edges; wide pulse select must not matter here
    apb(1'b1, ADDR_CTRL, 32'h00);
    apb(1'b1, ADDR_INC_UPR, 32'h02);
    apb(1'b1, ADDR_CLK, 32'he2);
    apb(1'b1, ADDR_CTRL, 32'h80);
    edges(8, 0);
    hi = 0;
    edges(16, 0);
    chk("toggle high", 32'h8, hi);
    sleep_req <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      apb(1'b1, ADDR_CLK, {24'h0, p[2:0], 5'h0});
      apb(1'b1, ADDR_CTRL, 32'h81);
      edges(8, 2);
      hi = 0;
      edges(16, 2);
      chk("pulse high", 32'h2 << p, hi);
      chk("keep", 32'h1, {31'h0, fast_osc_keep});
    end
    // A 128-period pulse outlasts the 8-edge overflow period: level stays high
    apb(1'b1, ADDR_CLK, 32'he0);
    edges(8, 2);
    hi = 0;
    edges(16, 2);
    chk("long pulse", 32'd16, hi);
    resetn <= 1'b0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("keep", 32'h0, {31'h0, fast_osc_keep});
    apb(1'b0, ADDR_INC_UPR, 32'h0);
    apb(1'b0, ADDR_CLK, 32'h0);
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    tally_and_finish();
  end
endmodule

// [hdl/ncosc_pkg.sv]
// Package: register map, field layout and reset values of the oscillator block
package ncosc_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses (word aligned)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CLK      = 8'h04;
  localparam logic [7:0] ADDR_ACC_LOW  = 8'h08;
  localparam logic [7:0] ADDR_ACC_HIGH = 8'h0c;
  localparam logic [7:0] ADDR_ACC_UPR  = 8'h10;
  localparam logic [7:0] ADDR_INC_LOW  = 8'h14;
  localparam logic [7:0] ADDR_INC_HIGH = 8'h18;
  localparam logic [7:0] ADDR_INC_UPR  = 8'h1c;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;
  localparam logic [7:0] ADDR_MASK     = 8'h24;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_OUT_BIT  = 5;
  localparam int CTRL_POL_BIT  = 4;
  localparam int CTRL_PFM_BIT  = 0;
  localparam int CTRL_GIE_BIT  = 3;
  localparam int CTRL_PERIPHERAL_INT_ENABLE_BIT = 2;
  localparam int CTRL_OVIE_BIT = 1;
  localparam int PWS_LSB       = 5;
  localparam int CKS_LSB       = 0;
  localparam int STAT_OVF_BIT  = 0;

  // ----------------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [19:0] RST_WORD = 20'h00000;
  localparam logic [7:0]  RST_CNT  = 8'h00;
  localparam logic [1:0]  CKS_FAST = 2'h0;
  localparam logic [1:0]  CKS_SYS  = 2'h1;
  localparam logic [1:0]  CKS_LC1  = 2'h2;

  typedef struct packed {
    logic fast_internal_osc;
    logic sys_osc;
    logic logic_cell_one_output;
  } ncosc_clk_src_t;

  typedef enum logic [1:0] {NCOSC_IDLE, NCOSC_PULSE} ncosc_out_st_t;

endpackage

// [hdl/ncosc_top.sv]
// Numerically controlled oscillator with APB register slave
//
// Behaviour
// - Every accumulator overflow sets the overflow flag.
// - The interrupt line rises only with module, overflow, peripheral and global enables set.
// - The overflow flag stays set until software clears it; hardware never clears it.
// - Any reset clears every register of the block to zero.
// - The block runs from its selected input clock, also during sleep.
// - Enabled with the fast oscillator selected, the block keeps that oscillator requested while sleep is requested.
// - Pulse width select gives an active time of 2^n input clock periods, 1 to 128.
// - Pulse width select acts only in pulse-frequency mode.
// - A pulse longer than the overflow period stays high only if an overflow falls on its last edge.
// - Clock source 00 fast oscillator, 01 system clock, 10 logic cell one, 11 reserved.
// - Accumulator bits 7..0 are a read/write low byte that resets to zero.
// - The increment is 20 bits from upper, high and low bytes; upper bits 7..4 read zero.
// - Increment bits 15..8 are a read/write high byte resetting to zero.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns

module ncosc_top
  import ncosc_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Input clock candidates, sampled as levels
  input  wire ncosc_pkg::ncosc_clk_src_t clk_src,
  // Sleep indication from the core
  input  wire logic                  sleep_req,
  // Outputs
  output logic                       osc_out,
  output logic                       fast_osc_keep,
  output logic                       irq
);
  import ncosc_pkg::*;

  // ----------------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]  ctrl_r;
  logic [7:0]  clk_ctrl_r;
  logic [19:0] phase_accumulator_r;
  logic [19:0] phase_increment_r;
  logic        overflow_flag_r;
  logic [7:0]  mask_r;
  logic        src_prev_r;

  logic        module_enable;
  logic        pfm_mode;
  logic [2:0]  pulse_width_select;
  logic [1:0]  clock_source_select;
  logic        sel_clk;
  logic        in_edge;
  logic [20:0] acc_sum;
  logic        ovf;

  logic        bus_first;
  logic        wr_en;
  logic        rd_en;

  assign module_enable       = ctrl_r[CTRL_EN_BIT];
  assign pfm_mode            = ctrl_r[CTRL_PFM_BIT];
  assign pulse_width_select  = clk_ctrl_r[PWS_LSB +: 3];
  assign clock_source_select = clk_ctrl_r[CKS_LSB +: 2];
  // Writes land on the answer edge; read side effects go with the data capture edge
  assign bus_first = psel && penable && !pready;
  assign wr_en     = psel && penable && pready && pwrite;
  assign rd_en     = bus_first && !pwrite;

  // ----------------------------------------------------------------------
  // Input clock selection
  // ----------------------------------------------------------------------
  // Reserved code selects nothing so the block stalls.
  // Switching source while the new one is high can count one false edge:
  // software should clear the enable before changing the source.
  always_comb begin
    case (clock_source_select)
      CKS_FAST: sel_clk = clk_src.fast_internal_osc;
      CKS_SYS:  sel_clk = clk_src.sys_osc;
      CKS_LC1:  sel_clk = clk_src.logic_cell_one_output;
      default:  sel_clk = 1'b0;
    endcase
  end

  // Input clock edges are counted independently of the core, so sleep has no effect
  assign in_edge = sel_clk && !src_prev_r && module_enable;
  assign acc_sum = {1'b0, phase_accumulator_r} + {1'b0, phase_increment_r};
  assign ovf     = in_edge && acc_sum[20];

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= sel_clk;
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // ----------------------------------------------------------------------
  // Control, clock select and mask registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r <= RST_BYTE;
    end else if (wr_en && hit(paddr, ADDR_CTRL)) begin
      // Bit 6 is the read-only output level, so it is never stored
      ctrl_r <= pwdata[7:0] & 8'hbf;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      clk_ctrl_r <= RST_BYTE;
    end else if (wr_en && hit(paddr, ADDR_CLK)) begin
      // Bits 4..2 are unused and read as zero
      clk_ctrl_r <= pwdata[7:0] & 8'he3;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mask_r <= RST_BYTE;
    end else if (wr_en && hit(paddr, ADDR_MASK)) begin
      mask_r <= {7'h00, pwdata[STAT_OVF_BIT]};
    end
  end

  // ----------------------------------------------------------------------
  // Increment bytes
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      phase_increment_r <= RST_WORD;
    end else if (wr_en) begin
      if (hit(paddr, ADDR_INC_LOW)) phase_increment_r[7:0] <= pwdata[7:0];
      if (hit(paddr, ADDR_INC_HIGH)) phase_increment_r[15:8] <= pwdata[7:0];
      if (hit(paddr, ADDR_INC_UPR)) phase_increment_r[19:16] <= pwdata[3:0];
    end
  end

  // ----------------------------------------------------------------------
  // Phase accumulator
  // ----------------------------------------------------------------------
  // A bus write wins over a concurrent add. Bytes are written one at a time,
  // so software should stop the block before loading a new phase.
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      phase_accumulator_r <= RST_WORD;
    end else if (wr_en && hit(paddr, ADDR_ACC_LOW)) begin
      phase_accumulator_r[7:0] <= pwdata[7:0];
    end else if (wr_en && hit(paddr, ADDR_ACC_HIGH)) begin
      phase_accumulator_r[15:8] <= pwdata[7:0];
    end else if (wr_en && hit(paddr, ADDR_ACC_UPR)) begin
      phase_accumulator_r[19:16] <= pwdata[3:0];
    end else if (in_edge) begin
      phase_accumulator_r <= acc_sum[19:0];
    end
  end

  // ----------------------------------------------------------------------
  // Overflow flag: software writes 1 to the status flag bit or reads status to clear
  // ----------------------------------------------------------------------
  logic flag_clr;

  assign flag_clr = (wr_en && hit(paddr, ADDR_STATUS) && pwdata[STAT_OVF_BIT])
                 || (rd_en && hit(paddr, ADDR_STATUS));

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      overflow_flag_r <= 1'b0;
    end else if (ovf) begin
      overflow_flag_r <= 1'b1;
    end else if (flag_clr) begin
      overflow_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Output waveform
  // ----------------------------------------------------------------------
  ncosc_out_st_t out_st_r;
  logic [7:0]    pulse_cnt_r;
  logic [7:0]    pulse_len;
  logic          out_lvl_r;

  assign pulse_len = 8'h01 << pulse_width_select;

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      out_st_r    <= NCOSC_IDLE;
      pulse_cnt_r <= RST_CNT;
      out_lvl_r   <= 1'b0;
    end else if (!module_enable) begin
      out_st_r    <= NCOSC_IDLE;
      pulse_cnt_r <= RST_CNT;
      out_lvl_r   <= 1'b0;
    end else if (!pfm_mode) begin
      out_st_r <= NCOSC_IDLE;
      if (ovf) out_lvl_r <= !out_lvl_r;
    end else begin
      case (out_st_r)
        NCOSC_IDLE: begin
          if (ovf) begin
            out_st_r    <= NCOSC_PULSE;
            out_lvl_r   <= 1'b1;
            pulse_cnt_r <= pulse_len;
          end
        end
        NCOSC_PULSE: begin
          // Overflow before the last pulse edge is dropped; one on the last edge restarts the pulse
          if (in_edge && pulse_cnt_r == 8'h01) begin
            if (ovf) begin
              pulse_cnt_r <= pulse_len;
            end else begin
              out_st_r  <= NCOSC_IDLE;
              out_lvl_r <= 1'b0;
            end
          end else if (in_edge) begin
            pulse_cnt_r <= pulse_cnt_r - 8'h01;
          end
        end
        default: out_st_r <= NCOSC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Outputs and bus read
  // ----------------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    case (paddr)
      ADDR_CTRL:     rd_byte = {ctrl_r[7], out_lvl_r, ctrl_r[5:0]};
      ADDR_CLK:      rd_byte = clk_ctrl_r;
      ADDR_ACC_LOW:  rd_byte = phase_accumulator_r[7:0];
      ADDR_ACC_HIGH: rd_byte = phase_accumulator_r[15:8];
      ADDR_ACC_UPR:  rd_byte = {4'h0, phase_accumulator_r[19:16]};
      ADDR_INC_LOW:  rd_byte = phase_increment_r[7:0];
      ADDR_INC_HIGH: rd_byte = phase_increment_r[15:8];
      ADDR_INC_UPR:  rd_byte = {4'h0, phase_increment_r[19:16]};
      ADDR_STATUS:   rd_byte = {7'h00, overflow_flag_r};
      ADDR_MASK:     rd_byte = mask_r;
      default:       rd_byte = 8'h00;
    endcase
  end

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= ADDR_MASK) && (a[1:0] == 2'h0);
  endfunction

  // ----------------------------------------------------------------------
  // Bus answer: one wait state, the answer stands for one cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= bus_first;
      pslverr <= bus_first && !mapped(paddr);
      prdata  <= bus_first ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      osc_out <= 1'b0;
    end else begin
      osc_out <= out_lvl_r ^ ctrl_r[CTRL_POL_BIT];
    end
  end

  // Only a request: the oscillator itself lives outside this block
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fast_osc_keep <= 1'b0;
    end else begin
      fast_osc_keep <= module_enable && (clock_source_select == CKS_FAST)
                       && sleep_req;
    end
  end

  // Level interrupt; it falls one cycle after the flag or any enable clears
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq <= 1'b0;
    end else begin
      irq <= overflow_flag_r && module_enable && ctrl_r[CTRL_OVIE_BIT]
             && ctrl_r[CTRL_PERIPHERAL_INT_ENABLE_BIT] && ctrl_r[CTRL_GIE_BIT]
             && mask_r[STAT_OVF_BIT];
    end
  end

endmodule
